/* hw/auto_commutation_delay_manager.sv */
// Design decisions made here: strobed register access and the placing of the registers.
module auto_commutation_delay_manager (
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Position sensing events (asynchronous pins)
  input wire logic zero_event_in,
  input wire logic demag_event_in,
  input wire logic capture_event_in,
  input wire logic measure_event_in,
  input wire logic sim_zero_in,
  // Outputs
  output logic commutation_pulse,
  output logic ratio_irq,
  output logic zero_event_pin,
  output logic demag_event_pin
);
  logic [7:0] delay_timer_ff, zero_cross_capture_ff, zero_cross_previous_ff;
  logic [7:0] commutation_compare_ff, delay_weight_ff, demag_compare_ff;
  logic [3:0] ratio_divider_ff;
  logic [9:0] control_ff;
  logic [3:0] flags_ff;
  logic [7:0] phase_config_ff, phase_active_ff;
  logic [14:0] prescale_ff;
  logic armed_ff, recompute_ff, comm_ff, irq_ff, zpin_ff, dpin_ff;
  logic [15:0] rdata_ff;
  logic [4:0] sync1_ff, sync2_ff, sync3_ff;

  // Two flops per pin, third stage only for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 5'h0_0;
      sync2_ff <= 5'h0_0;
      sync3_ff <= 5'h0_0;
    end else begin
      sync1_ff <= {sim_zero_in, measure_event_in, capture_event_in, demag_event_in, zero_event_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic [4:0] rise;
  assign rise = sync2_ff & ~sync3_ff;
  logic hw_zero, demag, cap_ev, meas_ev, sim_zero;
  assign hw_zero = rise[0];
  assign demag = rise[1];
  assign cap_ev = rise[2];
  assign meas_ev = rise[3];
  assign sim_zero = rise[4];

  logic run, auto_mode, sim_comm, sensor_none;
  assign run = control_ff[delay_mgr_pkg::CTL_CLK_EN];
  assign auto_mode = control_ff[delay_mgr_pkg::CTL_AUTO];
  assign sim_comm = control_ff[delay_mgr_pkg::CTL_SIM_COMM];
  assign sensor_none = control_ff[delay_mgr_pkg::CTL_SEL_HI:delay_mgr_pkg::CTL_SEL_LO]
                       == delay_mgr_pkg::SEL_NONE;

  logic wr, rd;
  assign wr = reg_write;
  assign rd = reg_read;
  logic timer_wr_ok;
  assign timer_wr_ok = !run;

  // Tick of prescaler: 2**ratio clocks per count
  logic tick;
  logic [14:0] pre_limit;
  assign pre_limit = 15'((16'h0001 << ratio_divider_ff) - 16'h0001);
  assign tick = run && (prescale_ff >= pre_limit);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) prescale_ff <= 15'h0000;
    else if (!run || tick) prescale_ff <= 15'h0000;
    else prescale_ff <= prescale_ff + 15'h0001;
  end

  logic zero_any, overflow, shift_up, shift_down, cap_sel_ok;
  assign zero_any = run && auto_mode && (hw_zero || sim_zero);
  assign overflow = tick && delay_timer_ff == delay_mgr_pkg::TIMER_MAX;
  // A zero event at FFh wins over the step up
  assign shift_up = auto_mode && overflow && !zero_any
                    && ratio_divider_ff != delay_mgr_pkg::RATIO_MAX;
  assign shift_down = zero_any && delay_timer_ff < delay_mgr_pkg::TIMER_LOW
                      && ratio_divider_ff != delay_mgr_pkg::RATIO_MIN;

  // Multiplier: weight x selected capture / 256
  logic [7:0] sel_cap;
  logic [15:0] product;
  assign sel_cap = control_ff[delay_mgr_pkg::CTL_SRC_SEL] ? zero_cross_capture_ff
                   : zero_cross_previous_ff;
  assign product = delay_weight_ff * sel_cap;

  logic comm_hit;
  // No hit while registers shift, or the halved compare fires twice
  assign comm_hit = run && armed_ff && !recompute_ff && !zero_any && !shift_up
                    && commutation_compare_ff <= delay_timer_ff;

  // Timer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) delay_timer_ff <= 8'h00;
    else if (wr && reg_addr == delay_mgr_pkg::ADDR_DELAY_TIMER && timer_wr_ok)
      delay_timer_ff <= reg_wdata[7:0];
    else if (zero_any && shift_down) delay_timer_ff <= 8'h00;
    else if (zero_any) delay_timer_ff <= 8'h00;
    else if (shift_up) delay_timer_ff <= delay_mgr_pkg::TIMER_MEDIAN;
    else if (tick) delay_timer_ff <= delay_timer_ff + 8'h01;
  end

  // Captures
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      zero_cross_capture_ff <= 8'h00;
      zero_cross_previous_ff <= 8'h00;
    end else if (zero_any) begin
      zero_cross_previous_ff <= shift_down ? {zero_cross_capture_ff[6:0], 1'b0}
                                : zero_cross_capture_ff;
      if (hw_zero)
        zero_cross_capture_ff <= shift_down ? {delay_timer_ff[6:0], 1'b0}
                                 : delay_timer_ff;
      else if (shift_down)
        zero_cross_capture_ff <= {zero_cross_capture_ff[6:0], 1'b0};
    end else if (shift_up) begin
      zero_cross_capture_ff <= {1'b0, zero_cross_capture_ff[7:1]};
      zero_cross_previous_ff <= {1'b0, zero_cross_previous_ff[7:1]};
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_ZERO_CAPTURE) begin
      zero_cross_capture_ff <= reg_wdata[7:0];
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_ZERO_PREVIOUS && timer_wr_ok) begin
      zero_cross_previous_ff <= reg_wdata[7:0];
    end
  end

  // Recompute request after zero event or any shift, except in simulated commutation mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) recompute_ff <= 1'b0;
    else recompute_ff <= !sim_comm && (zero_any || shift_up);
  end

  // Compare register and arming
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      commutation_compare_ff <= 8'h00;
      armed_ff <= 1'b0;
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_COMM_COMPARE
                 && (timer_wr_ok || sim_comm)) begin
      commutation_compare_ff <= reg_wdata[7:0];
      armed_ff <= 1'b1;
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_CONTROL
                 && reg_wdata[delay_mgr_pkg::CTL_SIM_COMM] && !sim_comm) begin
      // Entering simulated mode drops a stale multiplier arm
      armed_ff <= 1'b0;
    end else if (recompute_ff) begin
      commutation_compare_ff <= product[15:8];
      armed_ff <= 1'b1;
    end else if (shift_up) begin
      commutation_compare_ff <= {1'b0, commutation_compare_ff[7:1]};
    end else if (shift_down) begin
      commutation_compare_ff <= {commutation_compare_ff[6:0], 1'b0};
    end else if (comm_hit) begin
      commutation_compare_ff <= delay_timer_ff;
      armed_ff <= 1'b0;
    end else if (!sim_comm && control_ff[delay_mgr_pkg::CTL_SIM_COMM] == 1'b0 && !run) begin
      armed_ff <= 1'b0;
    end
  end

  // Demag compare follows the shifts
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) demag_compare_ff <= 8'h00;
    else if (wr && reg_addr == delay_mgr_pkg::ADDR_DEMAG_COMPARE)
      demag_compare_ff <= reg_wdata[7:0];
    else if (shift_up) demag_compare_ff <= {1'b0, demag_compare_ff[7:1]};
    else if (shift_down) demag_compare_ff <= {demag_compare_ff[6:0], 1'b0};
  end

  // Ratio divider
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ratio_divider_ff <= 4'h0;
    else if (wr && reg_addr == delay_mgr_pkg::ADDR_RATIO_DIVIDER && timer_wr_ok)
      ratio_divider_ff <= reg_wdata[3:0];
    else if (shift_up) ratio_divider_ff <= ratio_divider_ff + 4'h1;
    else if (shift_down) ratio_divider_ff <= ratio_divider_ff - 4'h1;
  end

  // Simple config registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control_ff <= 10'h000;
      delay_weight_ff <= 8'h00;
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_CONTROL) begin
      control_ff <= reg_wdata[9:0];
    end else if (wr && reg_addr == delay_mgr_pkg::ADDR_DELAY_WEIGHT) begin
      delay_weight_ff <= reg_wdata[7:0];
    end
  end

  // Flags: hardware set beats software clear
  logic [3:0] nxt_flags;
  always_comb begin
    nxt_flags = flags_ff;
    if (wr && reg_addr == delay_mgr_pkg::ADDR_FLAGS)
      nxt_flags = reg_wdata[3:0];
    if (shift_up) nxt_flags[delay_mgr_pkg::FLG_INC] = 1'b1;
    if (shift_down) nxt_flags[delay_mgr_pkg::FLG_DEC] = 1'b1;
    if (auto_mode && overflow && sensor_none)
      nxt_flags[delay_mgr_pkg::FLG_OVF] = 1'b1;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) flags_ff <= 4'h0;
    else flags_ff <= nxt_flags;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) irq_ff <= 1'b0;
    else irq_ff <= flags_ff[delay_mgr_pkg::FLG_MASK]
                   && (flags_ff[delay_mgr_pkg::FLG_INC] || flags_ff[delay_mgr_pkg::FLG_DEC]);
  end

  // Phase step bits: preload then apply on a commutation hit; direct mode writes both at once
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_config_ff <= 8'h00;
      phase_active_ff <= 8'h00;
    end else begin
      if (wr && reg_addr == delay_mgr_pkg::ADDR_PHASE_CONFIG)
        phase_config_ff <= reg_wdata[7:0];
      if (control_ff[delay_mgr_pkg::CTL_DIRECT]) begin
        if (wr && reg_addr == delay_mgr_pkg::ADDR_PHASE_CONFIG)
          phase_active_ff <= reg_wdata[7:0];
      end else if (comm_hit) begin
        phase_active_ff <= phase_config_ff;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) comm_ff <= 1'b0;
    else comm_ff <= comm_hit;
  end

  // Debug pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      zpin_ff <= 1'b0;
      dpin_ff <= 1'b0;
    end else if (!control_ff[delay_mgr_pkg::CTL_DEBUG]) begin
      zpin_ff <= 1'b0;
      dpin_ff <= 1'b0;
    end else if (!sensor_none) begin
      if (cap_ev) dpin_ff <= !dpin_ff;
      if (meas_ev) zpin_ff <= !zpin_ff;
    end else if (control_ff[delay_mgr_pkg::CTL_SENSOR_MODE]) begin
      if (comm_hit) dpin_ff <= !dpin_ff;
      zpin_ff <= hw_zero;
    end else begin
      zpin_ff <= hw_zero || sim_zero || comm_hit;
      dpin_ff <= demag || comm_hit;
    end
  end

  // Read port
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rdata_ff <= 16'h0000;
    else if (rd) begin
      case (reg_addr)
        delay_mgr_pkg::ADDR_DELAY_TIMER: rdata_ff <= {8'h00, delay_timer_ff};
        delay_mgr_pkg::ADDR_ZERO_CAPTURE: rdata_ff <= {8'h00, zero_cross_capture_ff};
        delay_mgr_pkg::ADDR_ZERO_PREVIOUS: rdata_ff <= {8'h00, zero_cross_previous_ff};
        delay_mgr_pkg::ADDR_COMM_COMPARE: rdata_ff <= {8'h00, commutation_compare_ff};
        delay_mgr_pkg::ADDR_DELAY_WEIGHT: rdata_ff <= {8'h00, delay_weight_ff};
        delay_mgr_pkg::ADDR_DEMAG_COMPARE: rdata_ff <= {8'h00, demag_compare_ff};
        delay_mgr_pkg::ADDR_RATIO_DIVIDER: rdata_ff <= {12'h000, ratio_divider_ff};
        delay_mgr_pkg::ADDR_CONTROL: rdata_ff <= {6'h00, control_ff};
        delay_mgr_pkg::ADDR_FLAGS: rdata_ff <= {12'h000, flags_ff};
        delay_mgr_pkg::ADDR_PHASE_CONFIG: rdata_ff <= {8'h00, phase_config_ff};
        delay_mgr_pkg::ADDR_PHASE_ACTIVE: rdata_ff <= {8'h00, phase_active_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end else rdata_ff <= 16'h0000;
  end

  assign reg_rdata = rdata_ff;
  assign commutation_pulse = comm_ff;
  assign ratio_irq = irq_ff;
  assign zero_event_pin = zpin_ff;
  assign demag_event_pin = dpin_ff;

  AST_ZERO_RESETS: assert property (@(posedge clock) disable iff (!reset_n)
    (zero_any && !(wr && reg_addr == delay_mgr_pkg::ADDR_DELAY_TIMER)) |=> delay_timer_ff == 8'h00)
    else $error("timer not reset on zero event");
  AST_CAPTURE: assert property (@(posedge clock) disable iff (!reset_n)
    (zero_any && hw_zero && !shift_down) |=> zero_cross_capture_ff == $past(delay_timer_ff))
    else $error("capture mismatch");
  AST_MULT: assert property (@(posedge clock) disable iff (!reset_n)
    (recompute_ff && !wr) |=> commutation_compare_ff == $past(product[15:8]))
    else $error("compare not loaded from product");
  AST_HIT: assert property (@(posedge clock) disable iff (!reset_n)
    (comm_hit && !wr) |=> commutation_pulse ##0 !armed_ff[*1])
    else $error("commutation not issued");
  AST_UP: assert property (@(posedge clock) disable iff (!reset_n)
    shift_up |=> ratio_divider_ff == $past(ratio_divider_ff) + 4'h1
    && delay_timer_ff == delay_mgr_pkg::TIMER_MEDIAN) else $error("bad increment");
  AST_MIN: assert property (@(posedge clock) disable iff (!reset_n)
    (ratio_divider_ff == delay_mgr_pkg::RATIO_MIN && zero_any && !wr)
    |=> ratio_divider_ff == delay_mgr_pkg::RATIO_MIN && !$rose(flags_ff[delay_mgr_pkg::FLG_DEC]))
    else $error("ratio below zero");
  AST_MAX: assert property (@(posedge clock) disable iff (!reset_n)
    (overflow && ratio_divider_ff == 4'hF) |=> delay_timer_ff == 8'h00 && ratio_divider_ff == 4'hF)
    else $error("wrap at max ratio wrong");
  AST_LOCK: assert property (@(posedge clock) disable iff (!reset_n)
    (run && !shift_up && !shift_down) |=> $stable(ratio_divider_ff))
    else $error("ratio changed while running");
  AST_DEC: assert property (@(posedge clock) disable iff (!reset_n)
    shift_down |=> ratio_divider_ff == $past(ratio_divider_ff) - 4'h1
    && flags_ff[delay_mgr_pkg::FLG_DEC]) else $error("bad decrement");
  AST_IRQ_INC: assert property (@(posedge clock) disable iff (!reset_n)
    (shift_up && flags_ff[delay_mgr_pkg::FLG_MASK] && !wr) |-> ##2 ratio_irq)
    else $error("increment irq missing");
  AST_SIM_DISARM: assert property (@(posedge clock) disable iff (!reset_n)
    (wr && reg_addr == delay_mgr_pkg::ADDR_CONTROL && reg_wdata[delay_mgr_pkg::CTL_SIM_COMM]
    && !sim_comm) |=> !armed_ff) else $error("compare still armed in simulated mode");
  AST_DBG_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
    (control_ff[delay_mgr_pkg::CTL_DEBUG] && sensor_none
    && !control_ff[delay_mgr_pkg::CTL_SENSOR_MODE] && hw_zero) |=> zero_event_pin)
    else $error("zero event not shown on debug pin");
  AST_SPEED_DBG: assert property (@(posedge clock) disable iff (!reset_n)
    (control_ff[delay_mgr_pkg::CTL_DEBUG] && !sensor_none && cap_ev)
    |=> demag_event_pin != $past(demag_event_pin)) else $error("capture toggle missing");
  AST_SENSOR_DBG: assert property (@(posedge clock) disable iff (!reset_n)
    (control_ff[delay_mgr_pkg::CTL_DEBUG] && sensor_none
    && control_ff[delay_mgr_pkg::CTL_SENSOR_MODE] && comm_hit)
    |=> demag_event_pin != $past(demag_event_pin)) else $error("commutation toggle missing");
endmodule

/* hw/delay_mgr_pkg.sv */
package delay_mgr_pkg;
  localparam logic [3:0] ADDR_DELAY_TIMER = 4'h0;
  localparam logic [3:0] ADDR_ZERO_CAPTURE = 4'h1;
  localparam logic [3:0] ADDR_ZERO_PREVIOUS = 4'h2;
  localparam logic [3:0] ADDR_COMM_COMPARE = 4'h3;
  localparam logic [3:0] ADDR_DELAY_WEIGHT = 4'h4;
  localparam logic [3:0] ADDR_DEMAG_COMPARE = 4'h5;
  localparam logic [3:0] ADDR_RATIO_DIVIDER = 4'h6;
  localparam logic [3:0] ADDR_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam logic [3:0] ADDR_PHASE_CONFIG = 4'h9;
  localparam logic [3:0] ADDR_PHASE_ACTIVE = 4'hA;
  // Control register bits
  localparam int CTL_CLK_EN = 0;
  localparam int CTL_AUTO = 1;
  localparam int CTL_SIM_COMM = 2;
  localparam int CTL_SRC_SEL = 3;
  localparam int CTL_DEBUG = 4;
  localparam int CTL_DIRECT = 5;
  localparam int CTL_SENSOR_MODE = 6;
  localparam int CTL_SEL_LO = 8;
  localparam int CTL_SEL_HI = 9;
  // Flag register bits
  localparam int FLG_INC = 0;
  localparam int FLG_DEC = 1;
  localparam int FLG_OVF = 2;
  localparam int FLG_MASK = 3;
  localparam logic [7:0] TIMER_MEDIAN = 8'h80;
  localparam logic [7:0] TIMER_LOW = 8'h55;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [3:0] RATIO_MAX = 4'hF;
  localparam logic [3:0] RATIO_MIN = 4'h0;
  localparam logic [1:0] SEL_NONE = 2'h0;
endpackage

/* tb/sensor_model.sv */
module sensor_model #(
  parameter int HOLD = 4
) (
  // Clock
  input wire logic clock,
  // Event levels toward the block
  output logic zero_event_in,
  output logic demag_event_in,
  output logic capture_event_in,
  output logic measure_event_in,
  output logic sim_zero_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lvl = 5'h00;
  assign {sim_zero_in, measure_event_in, capture_event_in, demag_event_in, zero_event_in} = lvl;
  // Held past the three-stage input sampler so no edge is lost
  task automatic fire(input int idx);
    @(posedge clock);
    lvl[idx] <= 1'b1;
    repeat (HOLD) @(posedge clock);
    lvl[idx] <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata, got;
  logic zero_event_in, demag_event_in, capture_event_in, measure_event_in, sim_zero_in;
  logic commutation_pulse, ratio_irq, zero_event_pin, demag_event_pin, pin0, pin1;
  logic [16:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'hee93_7aab;
  logic [7:0] cap, wgt, cmp;
  int error_cnt = 0;
  int total_checks = 0;
  int pulse_cnt = 0;
  int zpin_cnt = 0;
  int dpin_cnt = 0;
  int cyc = 0;
  int c0, c1;

  always #2.5 clock = ~clock;

  auto_commutation_delay_manager dut_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .zero_event_in(zero_event_in), .demag_event_in(demag_event_in),
    .capture_event_in(capture_event_in), .measure_event_in(measure_event_in),
    .sim_zero_in(sim_zero_in), .commutation_pulse(commutation_pulse), .ratio_irq(ratio_irq),
    .zero_event_pin(zero_event_pin), .demag_event_pin(demag_event_pin));

  sensor_model sensor_u (.clock(clock), .zero_event_in(zero_event_in),
    .demag_event_in(demag_event_in), .capture_event_in(capture_event_in),
    .measure_event_in(measure_event_in), .sim_zero_in(sim_zero_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h to %h", $time, g, lo, hi);
    end
  endtask

  // Read data is judged one cycle after the strobe, oldest note first
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
    if (commutation_pulse === 1'b1) pulse_cnt++;
    if (zero_event_pin === 1'b1) zpin_cnt++;
    if (demag_event_pin === 1'b1) dpin_cnt++;
    if (rd_seen && exp_q.size() > 0) begin
      if (!exp_q[0][16]) chk(reg_rdata, exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
    rd_seen <= reg_read;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 got = reg_rdata;
  endtask

  task automatic wait_pulse(input int limit, input logic tog);
    c0 = pulse_cnt;
    pin0 = demag_event_pin;
    repeat (limit) begin
      @(posedge clock);
      #1;
      if (pulse_cnt > c0) break;
    end
    chk({15'h0000, pulse_cnt > c0}, 16'h0001);
    repeat (3) @(posedge clock);
    chk({15'h0000, demag_event_pin}, {15'h0000, pin0 ^ tog});
  endtask

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    seed = xs(seed);
    cap = 8'h40 | seed[5:0];
    wgt = 8'h80 | seed[14:8];
    cmp = 8'(({8'h00, wgt} * {8'h00, cap}) >> 8);
    wr(delay_mgr_pkg::ADDR_DELAY_TIMER, 16'h0060);
    wr(delay_mgr_pkg::ADDR_ZERO_CAPTURE, {8'h00, cap});
    wr(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, 16'h0033);
    wr(delay_mgr_pkg::ADDR_DELAY_WEIGHT, {8'h00, wgt});
    wr(delay_mgr_pkg::ADDR_RATIO_DIVIDER, {12'h000, seed[19:16]});
    rd(delay_mgr_pkg::ADDR_RATIO_DIVIDER, {13'h0000, seed[19:16]});
    wr(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 16'h0000);
    wr(4'hB, 16'h00FF);
    rd(delay_mgr_pkg::ADDR_DELAY_TIMER, 17'h0_0060);
    wr(delay_mgr_pkg::ADDR_FLAGS, 16'h0008);
    wr(delay_mgr_pkg::ADDR_CONTROL, 16'h0003);
    wr(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 16'h0005);
    wr(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, 16'h0011);
    rd(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 17'h0_0000);
    rd(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, 17'h0_0033);
    sensor_u.fire(4);
    repeat (6) @(posedge clock);
    rd(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, {9'h000, cap});
    rd(delay_mgr_pkg::ADDR_COMM_COMPARE, {9'h000, cmp});
    wait_pulse(300, 1'b0);
    rd(delay_mgr_pkg::ADDR_DELAY_TIMER, 17'h1_0000);
    chk_rng(got, {8'h00, cmp}, {8'h00, cmp} + 16'h0010);
    // Ratio step up once the timer passes FFh
    repeat (400) begin
      @(posedge clock);
      #1;
      if (ratio_irq === 1'b1) break;
    end
    chk({15'h0000, ratio_irq}, 16'h0001);
    rd(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 17'h0_0001);
    rd(delay_mgr_pkg::ADDR_FLAGS, 17'h0_000D);
    rd(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, {10'h000, cap[7:1]});
    rd(delay_mgr_pkg::ADDR_ZERO_CAPTURE, {10'h000, cap[7:1]});
    rd(delay_mgr_pkg::ADDR_DELAY_TIMER, 17'h1_0000);
    chk_rng(got, 16'h0080, 16'h0090);
    // Two quick zero events: the second sees a low timer
    wr(delay_mgr_pkg::ADDR_FLAGS, 16'h0008);
    sensor_u.fire(4);
    repeat (12) @(posedge clock);
    sensor_u.fire(4);
    repeat (6) @(posedge clock);
    chk({15'h0000, ratio_irq}, 16'h0001);
    rd(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 17'h0_0000);
    rd(delay_mgr_pkg::ADDR_FLAGS, 17'h0_000A);
    rd(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, {9'h000, cap & 8'hFE});
    rd(delay_mgr_pkg::ADDR_ZERO_CAPTURE, {9'h000, cap & 8'hFE});
    wr(delay_mgr_pkg::ADDR_FLAGS, 16'h0008);
    sensor_u.fire(4);
    wr(delay_mgr_pkg::ADDR_CONTROL, 16'h0057);
    rd(delay_mgr_pkg::ADDR_RATIO_DIVIDER, 17'h0_0000);
    rd(delay_mgr_pkg::ADDR_FLAGS, 17'h0_0008);
    chk({15'h0000, ratio_irq}, 16'h0000);
    c0 = pulse_cnt;
    repeat (100) @(posedge clock);
    #1 chk(16'(pulse_cnt - c0), 16'h0000);
    sensor_u.fire(1);
    sensor_u.fire(4);
    repeat (6) @(posedge clock);
    rd(delay_mgr_pkg::ADDR_DELAY_TIMER, 17'h1_0000);
    chk_rng(got, 16'h0000, 16'h0010);
    wr(delay_mgr_pkg::ADDR_PHASE_CONFIG, {8'h00, seed[31:24]});
    wr(delay_mgr_pkg::ADDR_COMM_COMPARE, 16'h0002);
    wait_pulse(8, 1'b1);
    rd(delay_mgr_pkg::ADDR_COMM_COMPARE, 17'h1_0000);
    chk_rng(got, 16'h0008, 16'h0030);
    rd(delay_mgr_pkg::ADDR_PHASE_ACTIVE, {9'h000, seed[31:24]});
    wr(delay_mgr_pkg::ADDR_COMM_COMPARE, 16'h0060);
    wait_pulse(300, 1'b1);
    rd(delay_mgr_pkg::ADDR_COMM_COMPARE, 17'h0_0060);
    c0 = zpin_cnt;
    sensor_u.fire(0);
    repeat (6) @(posedge clock);
    chk(16'(zpin_cnt - c0), 16'h0001);
    rd(delay_mgr_pkg::ADDR_ZERO_PREVIOUS, {9'h000, cap & 8'hFE});
    rd(delay_mgr_pkg::ADDR_ZERO_CAPTURE, 17'h1_0000);
    chk_rng(got, 16'h0060, 16'h0080);
    rd(delay_mgr_pkg::ADDR_DELAY_TIMER, 17'h1_0000);
    chk_rng(got, 16'h0000, 16'h0010);
    // Real-time debug pins with the timer stopped
    wr(delay_mgr_pkg::ADDR_CONTROL, 16'h0010);
    c0 = dpin_cnt;
    c1 = zpin_cnt;
    sensor_u.fire(1);
    sensor_u.fire(0);
    repeat (6) @(posedge clock);
    chk(16'(dpin_cnt - c0), 16'h0001);
    chk(16'(zpin_cnt - c1), 16'h0001);
    // Speed sensor selected: pins toggle per event
    wr(delay_mgr_pkg::ADDR_CONTROL, 16'h0110);
    pin0 = demag_event_pin;
    pin1 = zero_event_pin;
    sensor_u.fire(2);
    sensor_u.fire(3);
    repeat (6) @(posedge clock);
    chk({15'h0000, demag_event_pin}, {15'h0000, ~pin0});
    chk({15'h0000, zero_event_pin}, {15'h0000, ~pin1});
    repeat (4) @(posedge clock);
    wrap_up();
  end
endmodule
